// >>> rtl/dynamic_ram_4k_by_1_interface.sv
// Pin-level cycle logic of a 4096 x 1 dynamic RAM, sampled on a fast clock.
// Assumes strobe, select, mode, address and data pins are asynchronous.
//
// Summary of operation
// [RULE_01] Store 4096 one-bit words reached by a twelve-bit address.
// [RULE_02] Data pins and writes act only when unit select is low.
// [RULE_03] Controller drives unit select low by the strobe rising edge.
// [RULE_04] Unselected cycle: controller keeps select high while strobe high.
// [RULE_05] Unit select level is registered at strobe rising edge.
// [RULE_06] Operations happen only while the strobe, the only clock, is high.
// [RULE_07] Strobe low means standby and precharge, no read or write.
// [RULE_08] Mode pin high reads, low writes.
// [RULE_09] Read mode ignores the write data input.
// [RULE_10] Controller presents stable address by strobe rising edge.
// [RULE_11] Address is latched at cycle start, need not be held.
// [RULE_12] Writes happen while strobe high; data input sampled unlatched.
// [RULE_13] Read output floats whenever strobe is low.
// [RULE_14] Unselected at rising edge: output floats for the whole cycle.
// [RULE_15] Selected at rising edge: output stays on until strobe falls.
// [RULE_16] An enabled output drives low first, then valid data.
// [RULE_17] Read output is the inverse of the written bit.
// [RULE_18] Controller cycles all 64 rows within every 2 ms.
// [RULE_19] Any cycle addressing a row refreshes all its 64 bits.
// [RULE_20] Refresh may be unselected; written-mode refresh needs select high.
// [RULE_21] High six address bits may be anything during refresh.
// [RULE_22] After strobe rise, mode pin may only go high to low.
// [RULE_23] Mode low before strobe rise needs valid data at the rise.
// [RULE_24] Read-modify-write: read first, then drop mode pin to write.
`timescale 1ns/100ps
`include "dram_defs.svh"

module dynamic_ram_4k_by_1_interface
	import dram_pkg::*;
#(
	parameter int unsigned REFRESH_CYC =
		`REFRESH_MS * `NS_PER_MS / `CLK_PERIOD_NS
) (
	input  wire logic              i_clk_sys,
	input  wire logic              i_rst_b,
	input  wire logic              i_strobe,
	input  wire logic              i_unit_sel_b,
	input  wire logic              i_read_sel,
	input  wire logic [`ADDR_W-1:0] i_cell_addr,
	input  wire logic              i_write_bit_in,
	output logic                   o_read_bit,
	output logic                   o_read_bit_oe
);

	cell_port_if cell_if ();

	logic [`SYN_W-1:0]  sync_1_reg;
	logic [`SYN_W-1:0]  sync_2_reg;
	logic [`SYN_W-1:0]  pin_bus;
	logic               strobe_s;
	logic               sel_b_s;
	logic               rw_s;
	logic               din_s;
	logic [`ADDR_W-1:0] addr_s;
	logic               strobe_d_reg;
	logic               rise;
	logic               fall;
	logic               active;
	logic               write_now;
	logic               sel_reg;
	logic [`ADDR_W-1:0] addr_reg;
	cyc_state_t         state_reg;
	cyc_state_t         state_next;
	logic               oe_reg;
	logic               oe_next;
	logic               dout_reg;
	logic               dout_next;
	logic [1:0]         lead_cnt_reg;
	logic [1:0]         lead_next;

	assign pin_bus = {i_cell_addr, i_write_bit_in, i_read_sel,
	                  i_unit_sel_b, i_strobe};

	// Two stages on every pin; only the second stage feeds logic
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			sync_1_reg <= '0;
			sync_2_reg <= '0;
		end else begin
			sync_1_reg <= pin_bus;
			sync_2_reg <= sync_1_reg;
		end
	end

	assign strobe_s = sync_2_reg[`SYN_STB];
	assign sel_b_s  = sync_2_reg[`SYN_SEL];
	assign rw_s     = sync_2_reg[`SYN_RW];
	assign din_s    = sync_2_reg[`SYN_DIN];
	assign addr_s   = sync_2_reg[`SYN_ADDR +: `ADDR_W];

	// [RULE_06] strobe edges pace cycles
	assign rise   = strobe_s & ~strobe_d_reg;
	assign fall   = ~strobe_s & strobe_d_reg;
	assign active = (state_reg == ST_LEAD) || (state_reg == ST_DATA);

	// [RULE_02] writes need selection
	// [RULE_09] read mode ignores data
	// [RULE_12] unlatched data written
	assign write_now = active & sel_reg & strobe_s & ~rw_s;

	assign cell_if.addr   = addr_reg;
	assign cell_if.wr_en  = write_now;
	assign cell_if.wr_bit = din_s;
	// [RULE_19] every active cycle refreshes
	assign cell_if.touch  = (state_reg != ST_IDLE) && strobe_s;

	always_comb begin
		state_next = state_reg;
		oe_next    = oe_reg;
		dout_next  = dout_reg;
		lead_next  = lead_cnt_reg;
		case (state_reg)
			ST_IDLE: begin
				if (rise && !sel_b_s) begin
					// [RULE_16] low before data
					state_next = ST_LEAD;
					oe_next    = 1'b1;
					dout_next  = 1'b0;
					lead_next  = `LEAD_CYC;
				end else if (rise) begin
					// [RULE_14] unselected stays off
					state_next = ST_SKIP;
				end
			end
			ST_LEAD: begin
				if (lead_cnt_reg == `LEAD_ONE) begin
					state_next = ST_DATA;
				end else begin
					lead_next = lead_cnt_reg - `LEAD_ONE;
				end
			end
			ST_DATA: begin
				// [RULE_17] inverted output
				dout_next = ~cell_if.rd_bit;
			end
			ST_SKIP: begin
				state_next = ST_SKIP;
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
		// [RULE_07] standby on strobe low
		// [RULE_13] float when strobe low
		if (fall) begin
			state_next = ST_IDLE;
			oe_next    = 1'b0;
			dout_next  = 1'b0;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			strobe_d_reg <= 1'b0;
			state_reg    <= ST_IDLE;
			oe_reg       <= 1'b0;
			dout_reg     <= 1'b0;
			lead_cnt_reg <= 2'h0;
		end else begin
			strobe_d_reg <= strobe_s;
			state_reg    <= state_next;
			oe_reg       <= oe_next;
			dout_reg     <= dout_next;
			lead_cnt_reg <= lead_next;
		end
	end

	// [RULE_05] select registered
	// [RULE_11] address latched
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			sel_reg  <= 1'b0;
			addr_reg <= '0;
		end else if (rise) begin
			sel_reg  <= ~sel_b_s;
			addr_reg <= addr_s;
		end
	end

	assign o_read_bit    = dout_reg;
	assign o_read_bit_oe = oe_reg;

	cell_store #(
		.REFRESH_CYC (REFRESH_CYC)
	) u_cells (
		.i_clk_sys (i_clk_sys),
		.i_rst_b   (i_rst_b),
		.port      (cell_if.cells)
	);

	sel_capture_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b) // [RULE_05]
		rise |=> (sel_reg == !$past(sel_b_s)))
		else $error("select not captured at strobe rise");

	addr_hold_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b) // [RULE_11]
		(state_reg != ST_IDLE && $past(state_reg) != ST_IDLE)
		|-> $stable(addr_reg))
		else $error("latched address moved inside a cycle");

	float_low_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b) // [RULE_13]
		!strobe_s |=> !oe_reg)
		else $error("output driven while strobe low");

	unsel_off_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b) // [RULE_14]
		(state_reg == ST_SKIP) |-> (!oe_reg && !cell_if.wr_en))
		else $error("unselected cycle drove output or wrote");

	stay_on_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b) // [RULE_15]
		(oe_reg && strobe_s) |=> oe_reg)
		else $error("output dropped while strobe still high");

	lead_low_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b) // [RULE_16]
		(rise && !sel_b_s) ##1 strobe_s |-> (oe_reg && !dout_reg)
		##1 (!strobe_s || !dout_reg))
		else $error("output did not start low");

	write_inv_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b) // [RULE_17]
		cell_if.wr_en ##1 (state_reg == ST_DATA && strobe_s)
		|=> (dout_reg == !$past(cell_if.wr_bit, 2)))
		else $error("output is not the inverse of the written bit");

	write_mode_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b) // [RULE_08]
		cell_if.wr_en |-> (!rw_s && strobe_s && sel_reg))
		else $error("write outside selected write mode");

	standby_quiet_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b) // [RULE_07]
		(state_reg == ST_IDLE) |-> (!cell_if.wr_en && !cell_if.touch))
		else $error("cell activity during standby");

	write_data_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b) // [RULE_12]
		(state_reg == ST_DATA && strobe_s && !rw_s)
		|-> (cell_if.wr_en && cell_if.wr_bit == din_s))
		else $error("write data not taken directly from pin");

endmodule

// >>> rtl/dram_defs.svh
// Constants for the 4096 x 1 dynamic cell store and its cycle logic.
// Assumes inclusion by bare name from every rtl file that needs them.
`ifndef DRAM_DEFS_SVH
`define DRAM_DEFS_SVH

`define ADDR_W        12
`define WORDS         4096
`define ROW_W         6
`define ROWS          64
`define ROW_ONE       64'h0000_0000_0000_0001
`define SYN_W         16
`define SYN_STB       0
`define SYN_SEL       1
`define SYN_RW        2
`define SYN_DIN       3
`define SYN_ADDR      4
`define LEAD_CYC      2'h2
`define LEAD_ONE      2'h1
`define REFRESH_MS    32'h0000_0002
`define NS_PER_MS     32'h000F_4240
`define CLK_PERIOD_NS 32'h0000_0004
`define TICK_ONE      32'h0000_0001
`define TICK_ZERO     32'h0000_0000

`endif

// >>> rtl/dram_pkg.sv
// Types shared by the cycle logic of the dynamic RAM model.
// Assumes nothing beyond a SystemVerilog compiler.
package dram_pkg;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_LEAD = 2'b01,
		ST_DATA = 2'b10,
		ST_SKIP = 2'b11
	} cyc_state_t;

endpackage

// >>> rtl/cell_port_if.sv
// Carrier between the cycle logic and the cell store.
// Assumes both ends run on the same system clock.
`timescale 1ns/100ps
`include "dram_defs.svh"

interface cell_port_if;
	logic [`ADDR_W-1:0] addr;
	logic               wr_en;
	logic               wr_bit;
	logic               touch;
	logic               rd_bit;

	modport ctrl  (output addr, output wr_en, output wr_bit, output touch,
	               input rd_bit);
	modport cells (input addr, input wr_en, input wr_bit, input touch,
	               output rd_bit);
endinterface

// >>> rtl/cell_store.sv
// Cell array of 4096 single bits with row refresh bookkeeping.
// Assumes addr is stable while touch is high; low six bits pick the row.
`timescale 1ns/100ps
`include "dram_defs.svh"

module cell_store #(
	parameter int unsigned REFRESH_CYC = 500000
) (
	input wire logic     i_clk_sys,
	input wire logic     i_rst_b,
	cell_port_if.cells   port
);
	import dram_pkg::*;

	logic                mem [0:`WORDS-1];
	logic [`ROWS-1:0]    touched_reg;
	logic [`ROWS-1:0]    touched_next;
	logic [`ROWS-1:0]    lost_reg;
	logic [`ROWS-1:0]    lost_next;
	logic [`ROWS-1:0]    row_hit;
	logic [`ROWS-1:0]    row_wr;
	logic [`ROW_W-1:0]   row_sel;
	logic [31:0]         tick_reg;
	logic [31:0]         tick_next;
	logic                expire;

	assign row_sel = port.addr[`ROW_W-1:0];
	assign row_hit = port.touch ? (`ROW_ONE << row_sel) : '0;
	assign row_wr  = port.wr_en ? (`ROW_ONE << row_sel) : '0;
	assign expire  = (tick_reg == 32'(REFRESH_CYC - 1));
	assign tick_next = expire ? `TICK_ZERO : tick_reg + `TICK_ONE;

	// [RULE_19] row access refreshes
	assign touched_next = expire ? '0 : (touched_reg | row_hit);
	// A write revives a decayed row, and its other bits read their stored values again
	assign lost_next = (expire ? (lost_reg | ~(touched_reg | row_hit))
	                           : lost_reg) & ~row_wr;

	// [RULE_01] 4096 one-bit words
	always_ff @(posedge i_clk_sys) begin
		if (port.wr_en) begin
			mem[port.addr] <= port.wr_bit;
		end
	end

	assign port.rd_bit = mem[port.addr] & ~lost_reg[row_sel];

	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			touched_reg <= '0;
			lost_reg    <= '0;
			tick_reg    <= `TICK_ZERO;
		end else begin
			touched_reg <= touched_next;
			lost_reg    <= lost_next;
			tick_reg    <= tick_next;
		end
	end

	row_kept_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b) // [RULE_19]
		(port.touch && expire && !lost_reg[row_sel])
		|=> !lost_reg[$past(row_sel)])
		else $error("accessed row decayed at refresh deadline");

	row_decay_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b) // [RULE_19]
		(expire && !touched_reg[0] && !row_hit[0]) |=> lost_reg[0])
		else $error("unrefreshed row zero kept its data");

endmodule

// >>> verification/mem_ctrl_model.sv
// External controller model: strobe, select, mode, address and data pins.
// Assumes tb_top calls xfer; pins change only on falling clock edges.
`timescale 1ns/100ps
`include "dram_defs.svh"

module mem_ctrl_model (
	input  wire logic                i_clk_sys,
	input  wire logic                i_read_bit_oe,
	output logic                     o_strobe,
	output logic                     o_unit_sel_b,
	output logic                     o_read_sel,
	output logic [`ADDR_W-1:0]       o_cell_addr,
	output logic                     o_write_bit_in
);
	initial begin
		o_strobe       = 1'b0;
		o_unit_sel_b   = 1'b1;
		o_read_sel     = 1'b1;
		o_cell_addr    = 12'h000;
		o_write_bit_in = 1'b0;
	end

	// Kind 0 reads, 1 writes, 2 reads then writes back in one cycle
	task automatic xfer(input logic sel_b, input logic [1:0] kind,
		input logic [11:0] addr, input logic d0, input logic d1,
		input logic [31:0] junk);
		int n;
		n = 0;
		@(negedge i_clk_sys);
		o_unit_sel_b   <= sel_b;
		o_cell_addr    <= addr;
		o_read_sel     <= (kind != 2'h1);
		o_write_bit_in <= d0;
		o_strobe       <= 1'b1;
		while (!sel_b && i_read_bit_oe !== 1'b1 && n < 8) begin
			@(negedge i_clk_sys);
			n++;
		end
		repeat (2) @(negedge i_clk_sys);
		o_unit_sel_b <= sel_b | junk[12];
		o_cell_addr  <= junk[11:0];
		if (kind == 2'h0)
			o_write_bit_in <= junk[13];
		repeat (6) @(negedge i_clk_sys);
		// mode only falls while strobe high
		if (kind == 2'h2) begin
			o_read_sel     <= 1'b0;
			o_write_bit_in <= d1;
			repeat (6) @(negedge i_clk_sys);
		end
		o_strobe       <= 1'b0;
		o_read_sel     <= 1'b1;
		o_write_bit_in <= junk[14];
		o_unit_sel_b   <= junk[15];
		repeat (4) @(negedge i_clk_sys);
	endtask
endmodule

// >>> verification/tb_top.sv
// Self-checking bench for the 4096 x 1 dynamic RAM cycle logic.
// Assumes the rtl package, interface and modules are compiled first.
`timescale 1ns/100ps
`include "dram_defs.svh"
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin \
	n_fail++; $display("ERROR t=%0t got=%h exp=%h", $time, got, exp); end end

module tb_top;
	// Shortened refresh period of 2000 clocks keeps the run short
	localparam int unsigned REFRESH_CYC = 32'h0000_07D0;
	localparam logic [11:0] FIXED [3] = '{12'h0C5, 12'hFFF, 12'h000};
	logic               i_clk_sys;
	logic               i_rst_b;
	logic               strobe;
	logic               unit_sel_b;
	logic               read_sel;
	logic [`ADDR_W-1:0] cell_addr;
	logic               write_bit_in;
	logic               read_bit;
	logic               read_bit_oe;
	int                 n_fail;
	int                 checks_done;
	int                 low_cnt;
	logic               prev_oe, prev_stb, unsel, last_bit;
	logic               mem [`WORDS];
	logic [`ROWS-1:0]   dec;
	logic               exp_q [$];
	logic [11:0]        wr_q [$];
	logic [31:0]        rng;
	logic [31:0]        v;

	dynamic_ram_4k_by_1_interface #(
		.REFRESH_CYC (REFRESH_CYC)
	) dynamic_ram_4k_by_1_interface_inst (
		.i_clk_sys      (i_clk_sys),
		.i_rst_b        (i_rst_b),
		.i_strobe       (strobe),
		.i_unit_sel_b   (unit_sel_b),
		.i_read_sel     (read_sel),
		.i_cell_addr    (cell_addr),
		.i_write_bit_in (write_bit_in),
		.o_read_bit     (read_bit),
		.o_read_bit_oe  (read_bit_oe)
	);

	mem_ctrl_model mem_ctrl_model_inst (
		.i_clk_sys      (i_clk_sys),
		.i_read_bit_oe  (read_bit_oe),
		.o_strobe       (strobe),
		.o_unit_sel_b   (unit_sel_b),
		.o_read_sel     (read_sel),
		.o_cell_addr    (cell_addr),
		.o_write_bit_in (write_bit_in)
	);

	function automatic logic [31:0] xs();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng;
	endfunction

	// Notes the expected output, then runs the cycle on the pins
	task automatic cyc(input logic sel_b, input logic [1:0] k,
		input logic [11:0] a, input logic b0, input logic b1);
		if (!sel_b) begin
			if (k == 2'h1)
				mem[a] = b0;
			if (k == 2'h2)
				mem[a] = b1;
			if (k != 2'h0)
				dec[a[5:0]] = 1'b0;
			exp_q.push_back(dec[a[5:0]] ? 1'b1 : ~mem[a]);
		end
		mem_ctrl_model_inst.xfer(sel_b, k, a, b0, b1, xs());
	endtask

	task automatic sweep(input int skip);
		logic [31:0] r;
		for (int w = 0; w < `ROWS; w++) begin
			r = xs();
			if (w != skip)
				cyc(1'b1, {1'b0, r[0]}, {r[11:6], w[5:0]}, r[1], r[2]);
		end
	endtask

	task automatic blk(input int j, input bit rd);
		logic [31:0] r;
		logic [11:0] a;
		for (int i = 0; i < 8; i++) begin
			r = xs();
			if (!rd) begin
				a = (j == 0 && i < 3) ? FIXED[i] : r[11:0];
				wr_q.push_back(a);
				cyc(1'b0, 2'h1, a, r[16], r[17]);
			end else begin
				a = wr_q[r[31:20] % wr_q.size()];
				if (r[4:3] == 2'h0)
					cyc(1'b1, {1'b0, r[5]}, a, r[6], r[7]);
				else
					cyc(1'b0, r[2] ? 2'h2 : 2'h0, a, r[6], r[7]);
			end
		end
		sweep(-1);
	endtask

	task automatic print_verdict();
		if (n_fail == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial begin
		i_clk_sys = 1'b0;
		forever #2 i_clk_sys = ~i_clk_sys;
	end

	always @(negedge i_clk_sys) begin
		if (i_rst_b) begin
			low_cnt = strobe ? 0 : low_cnt + 1;
			if (strobe && !prev_stb)
				unsel = unit_sel_b;
			if (low_cnt >= 4)
				`CHK(read_bit_oe, 1'b0)
			if (unsel && strobe)
				`CHK(read_bit_oe, 1'b0)
			if (prev_oe && strobe)
				`CHK(read_bit_oe, 1'b1)
			if (read_bit_oe && !prev_oe)
				`CHK(read_bit, 1'b0)
			if (!read_bit_oe && prev_oe)
				`CHK(last_bit, exp_q.size() ? exp_q.pop_front() : 1'bx)
			if (read_bit_oe)
				last_bit = read_bit;
			prev_oe = read_bit_oe;
			prev_stb = strobe;
		end
	end

	initial begin
		#150000;
		n_fail++;
		print_verdict();
	end

	initial begin
		// Fixed seed 37966
		rng = 32'h0000_944E;
		{n_fail, checks_done, low_cnt} = '0;
		{prev_oe, prev_stb, unsel, last_bit} = '0;
		dec = '0;
		i_rst_b = 1'b0;
		repeat (3) @(posedge i_clk_sys);
		@(negedge i_clk_sys);
		i_rst_b = 1'b1;
		sweep(-1);
		for (int j = 0; j < 8; j++)
			blk(j % 4, j >= 4);
		// Starve row 5 over two periods, then decay and recovery
		repeat (7) sweep(5);
		dec[5] = 1'b1;
		v = xs();
		cyc(1'b0, 2'h0, 12'h0C5, v[5], v[6]);
		cyc(1'b0, 2'h0, 12'h0C5, v[7], v[8]);
		cyc(1'b0, 2'h1, 12'h3C5, v[0], v[0]);
		cyc(1'b0, 2'h0, 12'h3C5, v[1], v[2]);
		cyc(1'b0, 2'h0, 12'h0C5, v[3], v[4]);
		`CHK(exp_q.size(), 0)
		print_verdict();
	end
endmodule
